/* logic/acq_consts.svh */
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH
// register byte offsets
`define ACQ_CTRL    8'h00
`define ACQ_CMD     8'h04
`define ACQ_STAT    8'h08
`define ACQ_POST    8'h0c
`define ACQ_SEG     8'h10
`define ACQ_PRE     8'h14
`define ACQ_LVL     8'h18
`define ACQ_TCFG    8'h1c
`define ACQ_PW      8'h20
`define ACQ_RDADV   8'h24
`define ACQ_NOTE    8'h28
`define ACQ_MADR    8'h2c
`define ACQ_MDAT    8'h30
`define ACQ_TSLO    8'h34
`define ACQ_TSHI    8'h38
`define ACQ_SLOW    8'h3c
`define ACQ_PREAV   8'h40
`define ACQ_DIV     8'h44
`define ACQ_GPOST   8'h48
`define ACQ_TRGPOS  8'h4c
// field positions
`define CTRL_MODE   2:0
`define CTRL_STRM   3
`define CTRL_BOX    4
`define CTRL_BOXK   11:8
`define CTRL_TSREF  13:12
`define CTRL_GLVL   14
`define CMD_START   0
`define CMD_STOP    1
`define CMD_SWTRG   2
`define CMD_TSZERO  3
`define TCFG_COND   1:0
`define TCFG_REARM  2
`define TCFG_PWM    4:3
`define TCFG_E1LVL  5
`define TCFG_ORM    15:8
`define TCFG_ANDM   23:16
// reset values
`define RST_CTRL    32'h0000_0100
`define RST_POST    32'h0000_0010
`define RST_SEG     32'h0000_0040
`define RST_PRE     32'h0000_0010
`define RST_LVL     32'h8000_7000
`define RST_TCFG    32'h0000_0100
`define RST_PW      32'h0000_0004
`define RST_NOTE    32'h0000_0100
`define RST_DIV     32'h0000_0010
`define RST_GPOST   32'h0000_0010
`endif

/* logic/acq_pkg.sv */
package acq_pkg;
   typedef enum logic [2:0] {
      MD_RING, MD_STREAM, MD_MULTI, MD_GATE, MD_DUAL_RATE
   } acq_mode_e;
   typedef enum logic [2:0] {
      ST_IDLE, ST_FILL, ST_ARMED, ST_POST, ST_GATED, ST_DONE
   } acq_state_e;
   typedef enum logic [1:0] {
      TC_LEVEL, TC_EDGE, TC_WINDOW
   } acq_cond_e;
   typedef struct packed {
      logic ref_pls;
      logic gate;
      logic ext1;
      logic ext0_lo;
      logic ext0_hi;
   } acq_pins_s;
   typedef struct packed {
      logic [23:0] hi;
      logic [39:0] lo;
   } acq_ts_s;
endpackage

/* logic/acq_ctrl.sv */
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`include "acq_consts.svh"
// Contract
// RULE1: ring mode writes circularly until trigger, then post samples, stops.
// RULE2: pre-trigger count equals ring size minus post count.
// RULE3: streaming raises a data request so host moves data.
// RULE4: streaming uses the whole memory as buffer.
// RULE5: segmented mode fills one equal segment per trigger.
// RULE6: segmented mode re-arms itself between segments.
// RULE7: segments have programmable pre and post lengths.
// RULE8: segment count limited by memory, unlimited when streaming.
// RULE9: gated mode stores samples only while gate at set level.
// RULE10: gated mode keeps programmable samples before gate start.
// RULE11: gated mode keeps programmable samples after gate end.
// RULE12: gate segments limited by memory, unlimited when streaming.
// RULE13: each trigger writes its time into separate timestamp memory.
// RULE14: timestamp reference is start, zero command or external base.
// RULE15: dual-rate logs slowly while capturing fast segments on trigger.
// RULE16: dual-rate stores each trigger position as timestamp.
// RULE17: boxcar averages neighbouring samples, factor 2 to 256.
// RULE18: each boxcar result is stored as a 32 bit word.
// RULE19: trigger logic sees every sample while boxcar runs.
// RULE20: level, edge, window conditions, each with pulse-width qualifier.
// RULE21: re-arm, AND/OR combination, disabled channels still trigger.
// RULE22: ext0 two comparators; ext1 one comparator, edge or level.
module acq_ctrl import acq_pkg::*; #(
   parameter int NCH    = 4,
   parameter int SW     = 16,
   parameter int MEM_AW = 12,
   parameter int TS_AW  = 6,
   parameter int SL_AW  = 8
) (
   input  wire logic                REF_CLK,
   input  wire logic                RST_N,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [7:0]          PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic [NCH*SW-1:0]   ADC_DATA,
   input  wire logic                ADC_VALID,
   input  wire logic                EXT0_HI,
   input  wire logic                EXT0_LO,
   input  wire logic                EXT1_IN,
   input  wire logic                GATE_IN,
   input  wire logic                TS_REF_IN,
   output logic                     DATA_REQ,
   output logic                     ACQ_BUSY
);
   localparam int NS = NCH + 3;
   localparam logic [31:0] MEMW = 32'h1 << MEM_AW;

   ////////////////////////////////////////////////////////////////////////
   logic [1:0]  rs_q;
   logic        rst_n;
   acq_pins_s   p1_q, p2_q;
   logic        refp_q;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) rs_q <= 2'h0;
      else rs_q <= {rs_q[0], 1'b1};
   end
   assign rst_n = rs_q[1];
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         p1_q   <= '0;
         p2_q   <= '0;
         refp_q <= 1'b0;
      end else begin
         p1_q   <= {TS_REF_IN, GATE_IN, EXT1_IN, EXT0_LO, EXT0_HI};
         p2_q   <= p1_q;
         refp_q <= p2_q.ref_pls;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_q, post_q, seg_q, pre_q, lvl_q, tcfg_q, pw_q;
   logic [31:0] note_q, madr_q, div_q, gpost_q, rd_tot_q;
   logic [31:0] prdata_q;
   logic        err_q;
   logic        wr_acc, c_start, c_stop, c_sw, c_tsz;
   acq_mode_e   mode;
   assign wr_acc  = PSEL & PENABLE & PWRITE;
   assign c_start = wr_acc & PADDR == `ACQ_CMD & PWDATA[`CMD_START];
   assign c_stop  = wr_acc & PADDR == `ACQ_CMD & PWDATA[`CMD_STOP];
   assign c_sw    = wr_acc & PADDR == `ACQ_CMD & PWDATA[`CMD_SWTRG];
   assign c_tsz   = wr_acc & PADDR == `ACQ_CMD & PWDATA[`CMD_TSZERO];
   assign mode    = acq_mode_e'(ctrl_q[`CTRL_MODE]);

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q   <= `RST_CTRL;
         post_q   <= `RST_POST;
         seg_q    <= `RST_SEG;
         pre_q    <= `RST_PRE;
         lvl_q    <= `RST_LVL;
         tcfg_q   <= `RST_TCFG;
         pw_q     <= `RST_PW;
         note_q   <= `RST_NOTE;
         madr_q   <= '0;
         div_q    <= `RST_DIV;
         gpost_q  <= `RST_GPOST;
         rd_tot_q <= '0;
      end else begin
         if (c_start) rd_tot_q <= '0;
         if (wr_acc) begin
            case (PADDR)
               `ACQ_CTRL:  ctrl_q   <= PWDATA;
               `ACQ_POST:  post_q   <= PWDATA;
               `ACQ_SEG:   seg_q    <= PWDATA;
               `ACQ_PRE:   pre_q    <= PWDATA;
               `ACQ_LVL:   lvl_q    <= PWDATA;
               `ACQ_TCFG:  tcfg_q   <= PWDATA;
               `ACQ_PW:    pw_q     <= PWDATA;
               `ACQ_RDADV: rd_tot_q <= rd_tot_q + PWDATA;
               `ACQ_NOTE:  note_q   <= PWDATA;
               `ACQ_MADR:  madr_q   <= PWDATA;
               `ACQ_DIV:   div_q    <= PWDATA;
               `ACQ_GPOST: gpost_q  <= PWDATA;
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger sources: channels, ext0, ext1, software
   logic [NS-1:0] s_hi, s_lo, s_lvl, s_hit, s_ev, lvp_q, arm_q;
   logic [31:0]   pwc_q [NS];
   logic [SW-1:0] smp;
   logic [1:0]    pwm;
   logic [7:0]    orm, andm;
   logic          trig;
   assign pwm  = tcfg_q[`TCFG_PWM];
   assign orm  = tcfg_q[`TCFG_ORM];
   assign andm = tcfg_q[`TCFG_ANDM];

   always_comb begin
      smp = '0;
      for (int i = 0; i < NS; i++) begin
         if (i < NCH) begin
            // every sample is checked, boxcar or not
            smp     = ADC_DATA[i*SW +: SW]; // RULE19
            s_hi[i] = smp > lvl_q[16 +: SW];
            s_lo[i] = smp < lvl_q[0 +: SW];
            s_ev[i] = ADC_VALID;
         end else if (i == NCH) begin
            s_hi[i] = p2_q.ext0_hi; // RULE22
            s_lo[i] = p2_q.ext0_lo;
            s_ev[i] = 1'b1;
         end else if (i == NCH + 1) begin
            s_hi[i] = p2_q.ext1; // RULE22
            s_lo[i] = ~p2_q.ext1;
            s_ev[i] = 1'b1;
         end else begin
            s_hi[i] = c_sw;
            s_lo[i] = 1'b0;
            s_ev[i] = 1'b1;
         end
         s_lvl[i] = (tcfg_q[`TCFG_COND] == TC_WINDOW) ?
                    (s_hi[i] | s_lo[i]) : s_hi[i]; // RULE20
         case (pwm)
            2'h1: s_hit[i] = s_ev[i] & s_lvl[i]
                           & pwc_q[i] == pw_q - 32'h1; // RULE20
            2'h2: s_hit[i] = s_ev[i] & ~s_lvl[i] & lvp_q[i]
                           & pwc_q[i] < pw_q; // RULE20
            default: begin
               if (i == NCH + 1 && tcfg_q[`TCFG_E1LVL])
                  s_hit[i] = s_lvl[i];
               else if (tcfg_q[`TCFG_COND] == TC_LEVEL)
                  s_hit[i] = s_lvl[i];
               else
                  s_hit[i] = s_ev[i] & s_lvl[i] & ~lvp_q[i]
                           & (~tcfg_q[`TCFG_REARM] | arm_q[i]); // RULE21
            end
         endcase
      end
   end

   // masks cover any source, enabled for recording or not
   assign trig = |(s_hit & orm[NS-1:0])
               | ((|andm[NS-1:0]) & (|(s_hit & andm[NS-1:0]))
                  & (&(s_lvl | ~andm[NS-1:0]))); // RULE21

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         lvp_q <= '0;
         arm_q <= '0;
         for (int i = 0; i < NS; i++) pwc_q[i] <= '0;
      end else begin
         for (int i = 0; i < NS; i++) begin
            if (s_ev[i]) begin
               lvp_q[i] <= s_lvl[i];
               pwc_q[i] <= s_lvl[i] ? pwc_q[i] + 32'h1 : '0; // RULE20
               // re-arm needs the signal back below the low level
               if (s_lo[i]) arm_q[i] <= 1'b1; // RULE21
               else if (s_hit[i]) arm_q[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // boxcar accumulator
   logic [3:0]  bk;
   logic [8:0]  bcnt_q;
   logic [31:0] acc_q, word;
   logic        box, blast, dv;
   assign box   = ctrl_q[`CTRL_BOX];
   assign bk    = (ctrl_q[`CTRL_BOXK] < 4'h1) ? 4'h1 :
                  (ctrl_q[`CTRL_BOXK] > 4'h8) ? 4'h8 : ctrl_q[`CTRL_BOXK];
   assign blast = bcnt_q == (9'h1 << bk) - 9'h1; // RULE17
   assign word  = box ? acc_q + 32'(ADC_DATA[SW-1:0])
                      : 32'(ADC_DATA[SW-1:0]); // RULE18
   assign dv    = ADC_VALID & (~box | blast);
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         acc_q  <= '0;
         bcnt_q <= '0;
      end else if (c_start || (ADC_VALID && blast) || !box) begin
         acc_q  <= '0;
         bcnt_q <= '0;
      end else if (ADC_VALID) begin
         acc_q  <= word; // RULE17
         bcnt_q <= bcnt_q + 9'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // acquisition sequencer
   logic [31:0]      mem [1 << MEM_AW];
   acq_state_e       st_q;
   logic [31:0]      base_q, off_q, cnt_q, wr_tot_q, trgpos_q, fill;
   logic [31:0]      seg_len, post_len, pre_len, nb, off_nx;
   logic [MEM_AW-1:0] addr;
   logic             strm, full, want, we, gate_act, go, pend_q, ovr_q;
   logic             seg_end, ts_we;

   assign strm     = mode == MD_STREAM | ctrl_q[`CTRL_STRM];
   assign fill     = wr_tot_q - rd_tot_q;
   assign full     = strm & fill >= MEMW; // RULE8 RULE12
   assign gate_act = p2_q.gate == ctrl_q[`CTRL_GLVL]; // RULE9
   assign addr     = MEM_AW'(base_q + off_q);

   always_comb begin
      case (mode)
         MD_STREAM: begin
            seg_len = MEMW; // RULE4
            pre_len = '0;
            post_len = '0;
         end
         MD_MULTI, MD_DUAL_RATE: begin
            seg_len = seg_q; // RULE5
            pre_len = pre_q; // RULE7
            post_len = seg_q - pre_q; // RULE7
         end
         MD_GATE: begin
            seg_len = pre_q; // RULE10
            pre_len = pre_q;
            post_len = gpost_q; // RULE11
         end
         default: begin
            seg_len = MEMW;
            pre_len = '0;
            post_len = post_q; // RULE1
         end
      endcase
   end

   always_comb begin
      case (st_q)
         ST_FILL, ST_POST: want = 1'b1;
         ST_GATED: want = gate_act; // RULE9
         ST_ARMED: want = mode != MD_GATE | pre_q != '0;
         default: want = 1'b0;
      endcase
   end
   assign we = dv & want & ~full;
   // segments and rings wrap in their region; gated data runs on
   assign off_nx = !we ? off_q :
      (mode != MD_STREAM && off_q == seg_len - 32'h1 && (mode != MD_GATE
       || st_q == ST_FILL || st_q == ST_ARMED)) ? '0 : off_q + 32'h1;
   assign go = st_q == ST_ARMED & mode != MD_STREAM &
               (mode == MD_GATE ? gate_act : (pend_q | trig));
   assign seg_end = st_q == ST_POST & (cnt_q == '0 | (we & cnt_q == 32'h1));
   assign nb = (mode == MD_GATE) ? base_q + off_nx : base_q + seg_q;
   assign ts_we = go;

   always_ff @(posedge REF_CLK) begin
      if (we) mem[addr] <= word;
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
      end else if (c_start || c_stop) begin
         pend_q <= 1'b0;
      end else if (go) begin
         // an event in the consuming cycle stays pending
         pend_q <= pend_q & trig;
      end else if (seg_end && trig) begin
         pend_q <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_q     <= ST_IDLE;
         base_q   <= '0;
         off_q    <= '0;
         cnt_q    <= '0;
         wr_tot_q <= '0;
         trgpos_q <= '0;
         ovr_q    <= 1'b0;
      end else if (c_start) begin
         st_q     <= (pre_len == '0) ? ST_ARMED : ST_FILL;
         base_q   <= '0;
         off_q    <= '0;
         cnt_q    <= pre_len;
         wr_tot_q <= '0;
         ovr_q    <= 1'b0;
      end else if (c_stop) begin
         st_q <= ST_IDLE;
      end else begin
         off_q <= off_nx;
         if (we) wr_tot_q <= wr_tot_q + 32'h1;
         if (dv && want && full) ovr_q <= 1'b1;
         case (st_q)
            ST_FILL: begin
               if (we) cnt_q <= cnt_q - 32'h1;
               if (we && cnt_q == 32'h1) st_q <= ST_ARMED;
            end
            ST_ARMED: begin
               if (go) begin
                  trgpos_q <= 32'(addr);
                  cnt_q    <= post_len;
                  if (mode == MD_GATE) begin
                     base_q <= base_q + pre_q; // RULE10
                     off_q  <= '0;
                     st_q   <= ST_GATED;
                  end else begin
                     st_q <= ST_POST; // RULE1
                  end
               end
            end
            ST_GATED: begin
               if (!gate_act) st_q <= ST_POST; // RULE11
            end
            ST_POST: begin
               if (we) cnt_q <= cnt_q - 32'h1;
               if (seg_end) begin
                  if (mode == MD_RING) begin
                     st_q <= ST_DONE; // RULE1
                  end else if (!strm && nb + seg_len > MEMW) begin
                     st_q <= ST_DONE; // RULE8 RULE12
                  end else begin
                     // next segment starts without software
                     base_q <= (nb + seg_len > MEMW) ? '0 : nb;
                     off_q  <= '0;
                     cnt_q  <= pre_len;
                     st_q   <= (pre_len == '0) ? ST_ARMED
                                               : ST_FILL; // RULE6
                  end
               end
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timestamps and slow log
   acq_ts_s     ts_q;
   acq_ts_s     tsm [1 << TS_AW];
   logic [TS_AW-1:0] ts_n_q;
   logic [31:0] slm [1 << SL_AW];
   logic [SL_AW-1:0] sp_q;
   logic [31:0] sdiv_q;
   logic        run, slow_we;
   assign run     = st_q != ST_IDLE & st_q != ST_DONE;
   assign slow_we = mode == MD_DUAL_RATE & run & dv
                  & sdiv_q >= div_q - 32'h1; // RULE15

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ts_q <= '0;
      end else if (c_tsz || (c_start && ctrl_q[`CTRL_TSREF] == 2'h1)) begin
         ts_q <= '0; // RULE14
      end else if (ctrl_q[`CTRL_TSREF] == 2'h2) begin
         // external base: upper counts ref pulses, lower resets on them
         if (p2_q.ref_pls && !refp_q) begin
            ts_q.hi <= ts_q.hi + 24'h1; // RULE14
            ts_q.lo <= '0;
         end else begin
            ts_q.lo <= ts_q.lo + 40'h1;
         end
      end else begin
         ts_q <= ts_q + 64'h1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (ts_we) tsm[ts_n_q] <= ts_q; // RULE13 RULE16
      if (slow_we) slm[sp_q] <= word; // RULE15
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ts_n_q <= '0;
         sp_q   <= '0;
         sdiv_q <= '0;
      end else if (c_start) begin
         ts_n_q <= '0;
         sp_q   <= '0;
         sdiv_q <= '0;
      end else begin
         if (ts_we) ts_n_q <= ts_n_q + 1'b1; // RULE13
         if (slow_we) begin
            sp_q   <= sp_q + 1'b1;
            sdiv_q <= '0;
         end else if (dv && mode == MD_DUAL_RATE) begin
            sdiv_q <= sdiv_q + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb read: data captured in the setup cycle, zero wait states
   logic [31:0] rd;
   logic        hit;
   acq_ts_s     tsr;
   always_comb begin
      tsr = tsm[madr_q[TS_AW-1:0]];
      hit = 1'b1;
      case (PADDR)
         `ACQ_CTRL:   rd = ctrl_q;
         `ACQ_CMD:    rd = '0;
         `ACQ_STAT:   rd = {16'h0, 8'(ts_n_q), 3'h0, ovr_q, DATA_REQ,
                            3'(st_q)};
         `ACQ_POST:   rd = post_q;
         `ACQ_SEG:    rd = seg_q;
         `ACQ_PRE:    rd = pre_q;
         `ACQ_LVL:    rd = lvl_q;
         `ACQ_TCFG:   rd = tcfg_q;
         `ACQ_PW:     rd = pw_q;
         `ACQ_RDADV:  rd = fill;
         `ACQ_NOTE:   rd = note_q;
         `ACQ_MADR:   rd = madr_q;
         `ACQ_MDAT:   rd = mem[madr_q[MEM_AW-1:0]];
         `ACQ_TSLO:   rd = tsr.lo[31:0];
         `ACQ_TSHI:   rd = {tsr.hi, tsr.lo[39:32]};
         `ACQ_SLOW:   rd = slm[madr_q[SL_AW-1:0]];
         `ACQ_PREAV:  rd = MEMW - post_q; // RULE2
         `ACQ_DIV:    rd = div_q;
         `ACQ_GPOST:  rd = gpost_q;
         `ACQ_TRGPOS: rd = trgpos_q;
         default: begin
            rd  = '0;
            hit = 1'b0;
         end
      endcase
   end

   logic req_q;
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= '0;
         err_q    <= 1'b0;
         req_q    <= 1'b0;
      end else begin
         if (PSEL && !PENABLE) begin
            prdata_q <= PWRITE ? '0 : rd;
            err_q    <= ~hit;
         end
         req_q <= strm & run & fill >= note_q; // RULE3
      end
   end

   assign PRDATA   = prdata_q;
   assign PREADY   = 1'b1;
   assign PSLVERR  = PSEL & PENABLE & err_q;
   assign DATA_REQ = req_q;
   assign ACQ_BUSY = run;
endmodule // acq_ctrl

/* verif/acq_adc_model.sv */
`timescale 1ns/1ps
module acq_adc_model #(
   parameter int NCH = 4,
   parameter int SW  = 16
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              slow,
   output logic      [NCH*SW-1:0] adc_data,
   output logic                   adc_valid
);
   logic [SW-1:0] cnt_q;
   logic          ph_q;
   // ramp per strobe; slow strobes every other cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         ph_q  <= 1'b0;
      end else begin
         ph_q <= slow ? !ph_q : 1'b1;
         if (ph_q) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
   assign adc_valid = ph_q;
   // inverse between strobes so stale data never looks valid
   assign adc_data = {NCH{ph_q ? cnt_q : ~cnt_q}};
endmodule // acq_adc_model

/* verif/acq_ctrl_props.sv */
`timescale 1ns/1ps
module acq_ctrl_props (
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        DATA_REQ,
   input wire logic        ACQ_BUSY
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   logic acc;
   logic cmd;
   assign acc = PSEL && PENABLE;
   assign cmd = acc && PWRITE && PADDR == 8'h04;
   ////////////////////////////////////////////////////////////
   ready_high_a: assert property (PREADY)
      else $error("pready low");
   err_unmap_a: assert property (acc && PADDR > 8'h4c |->
      PSLVERR && (PWRITE || PRDATA == 32'h0)) else $error("unmapped ok");
   err_map_a: assert property (acc && PADDR <= 8'h4c &&
      PADDR[1:0] == 2'h0 |-> !PSLVERR) else $error("mapped refused");
   err_phase_a: assert property (PSLVERR |-> acc)
      else $error("error outside access");
   rdata_hold_a: assert property (acc |=> $stable(PRDATA))
      else $error("read data moved");
   start_busy_a: assert property (cmd && PWDATA[1:0] == 2'h1 |->
      ##[1:3] ACQ_BUSY) else $error("start ignored");
   stop_idle_a: assert property (cmd && PWDATA[1] |-> ##[1:3] !ACQ_BUSY)
      else $error("stop ignored");
   // a registered command pulse may lag the write by one cycle
   idle_hold_a: assert property (!ACQ_BUSY && !cmd &&
      !$past(cmd) |=> !ACQ_BUSY) else $error("self start");
   req_busy_a: assert property ($rose(DATA_REQ) |-> ACQ_BUSY)
      else $error("request while idle");
   cover property (cmd && PWDATA[2]);
   cover property ($fell(ACQ_BUSY));
   cover property ($rose(DATA_REQ));
endmodule // acq_ctrl_props
bind acq_ctrl acq_ctrl_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .DATA_REQ(DATA_REQ), .ACQ_BUSY(ACQ_BUSY));

/* verif/test_acq_ctrl.sv */
`timescale 1ns/1ps
`include "acq_consts.svh"
module test_acq_ctrl import acq_pkg::*;;
   localparam int MAW = 6;
   localparam int MEM = 1 << MAW;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [63:0] adc_data;
   logic        adc_valid;
   logic        slow = 1'b0;
   logic        data_req;
   logic        busy;
   logic        low = 1'b0;
   logic [31:0] seed = 32'he98e659e;
   logic [31:0] q;
   logic [31:0] v;
   int          n;
   int          fails = 0;
   int          check_count = 0;
   logic [7:0]  ra[10] = '{`ACQ_CTRL, `ACQ_POST, `ACQ_SEG, `ACQ_PRE,
      `ACQ_LVL, `ACQ_TCFG, `ACQ_PW, `ACQ_NOTE, `ACQ_DIV, `ACQ_GPOST};
   logic [31:0] rv[10] = '{`RST_CTRL, `RST_POST, `RST_SEG, `RST_PRE,
      `RST_LVL, `RST_TCFG, `RST_PW, `RST_NOTE, `RST_DIV, `RST_GPOST};
   always #50 clk = ~clk;
   acq_adc_model u_adc (.clk(clk), .rst_n(rst_n), .slow(slow),
      .adc_data(adc_data), .adc_valid(adc_valid));
   acq_ctrl #(.MEM_AW(MAW)) dut (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .ADC_DATA(adc_data), .ADC_VALID(adc_valid), .EXT0_HI(low),
      .EXT0_LO(low), .EXT1_IN(low), .GATE_IN(low), .TS_REF_IN(low),
      .DATA_REQ(data_req), .ACQ_BUSY(busy));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] stat_exp(input acq_state_e s,
                                            input logic [7:0] ts);
      return {16'h0, ts, 5'h0, s};
   endfunction
   function automatic logic in_rng(input logic [31:0] x, lo, hi);
      return x >= lo && x <= hi;
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bounded wait on data request or on the end of acquisition
   task automatic await(input bit req);
      n = 0;
      while ((req ? data_req !== 1'b1 : busy === 1'b1) && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (n >= 400) fails++;
   endtask
   task automatic results();
      if (fails == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #500000;
      fails++;
      results();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk("reset value", q, rv[i]);
      end
      apb(1'b1, 8'h50, 32'hffff_ffff);
      apb(1'b0, 8'h50, 32'h0);
      chk("unmapped", q, 32'h0);
      // only the software trigger may fire, so ramp data stays harmless
      apb(1'b1, `ACQ_TCFG, 32'h0000_4000);
      seed = lfsr(seed);
      v = 32'd8 + seed[3:0];
      apb(1'b1, `ACQ_POST, v);
      apb(1'b1, `ACQ_CTRL, 32'h0000_0100);
      apb(1'b0, `ACQ_PREAV, 32'h0);
      chk("pre count", q, MEM - v);
      apb(1'b1, `ACQ_CMD, 32'h1);
      repeat (MEM + 8) @(posedge clk);
      chk("ring armed", busy, 1'b1);
      apb(1'b1, `ACQ_CMD, 32'h4);
      await(1'b0);
      chk("post span", in_rng(n, v - 1, v + 4), 1'b1);
      apb(1'b0, `ACQ_STAT, 32'h0);
      chk("ring stat", q, stat_exp(ST_DONE, 8'd1));
      apb(1'b1, `ACQ_SEG, 32'h10);
      apb(1'b1, `ACQ_PRE, 32'h4);
      apb(1'b1, `ACQ_CTRL, 32'h0000_0102);
      apb(1'b1, `ACQ_CMD, 32'h1);
      for (int i = 0; i < MEM / 16; i++) begin
         repeat (24) @(posedge clk);
         chk("rearmed", busy, 1'b1);
         apb(1'b1, `ACQ_CMD, 32'h4);
      end
      await(1'b0);
      apb(1'b0, `ACQ_STAT, 32'h0);
      chk("multi stat", q, stat_exp(ST_DONE, 8'd4));
      slow <= 1'b1;
      seed = lfsr(seed);
      v = 32'd8 + seed[4:0];
      apb(1'b1, `ACQ_NOTE, v);
      apb(1'b1, `ACQ_CTRL, 32'h0000_0101);
      apb(1'b1, `ACQ_CMD, 32'h1);
      await(1'b1);
      apb(1'b0, `ACQ_RDADV, 32'h0);
      chk("req fill", in_rng(q, v, v + 4), 1'b1);
      repeat (2 * MEM + 20) @(posedge clk);
      apb(1'b0, `ACQ_RDADV, 32'h0);
      chk("full fill", q, MEM);
      apb(1'b0, `ACQ_STAT, 32'h0);
      chk("overrun", q[4], 1'b1);
      apb(1'b1, `ACQ_RDADV, MEM);
      apb(1'b0, `ACQ_RDADV, 32'h0);
      chk("drained", q < v, 1'b1);
      chk("req low", data_req, 1'b0);
      apb(1'b1, `ACQ_CMD, 32'h2);
      repeat (4) @(posedge clk);
      chk("stopped", busy, 1'b0);
      results();
   end
endmodule // test_acq_ctrl
